// file: core/ptc_regs.svh
// Constants for the page-table pointer cache and walker: field positions,
// entry-type codes, index positions and reset values.
// Assumes inclusion from the package and the walker module only.
`ifndef PTC_REGS_SVH
`define PTC_REGS_SVH

// =====================================================================
// Entry-type codes in bits 1:0 of every table word
`define PTC_ENTRY_INVALID 2'h0
`define PTC_ENTRY_POINTER 2'h1
`define PTC_ENTRY_TRANSLATION 2'h2
`define PTC_ENTRY_RESERVED 2'h3

// =====================================================================
// Translation entry field positions
`define PTC_PAGE_NUMBER_HI 31
`define PTC_PAGE_NUMBER_LO 8
`define PTC_CACHEABLE_BIT 7
`define PTC_MODIFIED_BIT 6
`define PTC_REFERENCED_BIT 5
`define PTC_ACCESS_HI 4
`define PTC_ACCESS_LO 2

// =====================================================================
// Virtual address index fields and tag width
`define PTC_INDEX1_HI 31
`define PTC_INDEX1_LO 24
`define PTC_INDEX2_HI 23
`define PTC_INDEX2_LO 18
`define PTC_INDEX3_HI 17
`define PTC_INDEX3_LO 12
`define PTC_TAG_W 14

// =====================================================================
// Walk levels and reset values
`define PTC_LEVEL_CONTEXT 2'h0
`define PTC_LEVEL_1 2'h1
`define PTC_LEVEL_2 2'h2
`define PTC_LEVEL_3 2'h3
`define PTC_WORD_RESET 32'h0000_0000

`endif

// file: core/ptc_pkg.sv
// Types shared by the walker: request and result carriers, walk states.
// Assumes the constants header is on the include path.
`include "ptc_regs.svh"

package ptc_pkg;

  // ===================================================================
  // Walk states
  typedef enum logic [1:0] {
    PTC_IDLE,
    PTC_FETCH,
    PTC_UPDATE
  } ptc_state_t;

  // ===================================================================
  // Miss request from the TLB side
  typedef struct packed {
    logic [31:0] va;
    logic is_instr;
    logic is_write;
    logic no_fill;
  } ptc_miss_t;

  // ===================================================================
  // Walk result back to the TLB side
  typedef struct packed {
    logic [35:0] pa;
    logic [31:0] translation_entry;
    logic [1:0] level;
    logic err_invalid;
    logic err_translation;
  } ptc_result_t;

endpackage

// file: core/ptc_walker.sv
// Page-table walker with three-entry pointer cache and address forming.
// Assumes a word-wide memory port that answers each request with one ack.
`timescale 1ns/10ps
`include "ptc_regs.svh"

module ptc_walker #(
  parameter int PA_W = 36
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Miss request and result
  input wire logic miss_valid,
  input wire ptc_pkg::ptc_miss_t miss,
  output ptc_pkg::ptc_result_t result,
  output logic miss_ready,
  output logic result_valid,
  // Context and control
  input wire logic [11:0] context_number_reg,
  input wire logic context_number_write,
  input wire logic [21:0] context_table_base_reg,
  input wire logic context_table_base_write,
  input wire logic tlb_flush,
  input wire logic sys_cacheable_bit,
  input wire logic boot_select_bit,
  input wire logic translate_enable_bit,
  // Physical memory port
  output logic mem_req,
  output logic mem_we,
  output logic [35:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic [31:0] mem_rdata,
  // Bus indicators
  output logic bus_cacheable_indicator,
  output logic boot_local_indicator,
  // Cache state view
  output logic [2:0] pointer_cache_valid
);

  // ===================================================================
  // Elaboration check: address forming is fixed at 36 bits
  if (PA_W != 36) begin : g_bad_width
    $error("ptc_walker serves a 36-bit physical address only");
  end

  // ===================================================================
  // Whole module state
  typedef struct packed {
    ptc_pkg::ptc_state_t st;
    logic [1:0] lvl;
    ptc_pkg::ptc_miss_t req;
    logic [35:0] addr;
    logic [31:0] wdata;
    logic mem_req;
    logic mem_we;
    logic root_v;
    logic [31:0] root;
    logic ip_v;
    logic [31:0] ip;
    logic [`PTC_TAG_W-1:0] instr_index_tag;
    logic dp_v;
    logic [31:0] dp;
    logic [`PTC_TAG_W-1:0] data_index_tag;
    logic ready;
    logic done;
    ptc_pkg::ptc_result_t res;
    logic bus_c;
    logic boot_l;
  } ptc_state_all_t;

  ptc_state_all_t s_q;
  ptc_state_all_t s_d;

  logic [`PTC_TAG_W-1:0] miss_tag;
  logic hit_instr;
  logic hit_data;
  logic [1:0] rd_type;
  logic inv_all;

  // Tag compare on the incoming miss
  assign miss_tag = miss.va[`PTC_INDEX1_HI:`PTC_INDEX2_LO];
  assign hit_instr = miss.is_instr && s_q.ip_v && (s_q.instr_index_tag == miss_tag);
  assign hit_data = !miss.is_instr && s_q.dp_v && (s_q.data_index_tag == miss_tag);
  assign rd_type = mem_rdata[1:0];
  assign inv_all = context_number_write || context_table_base_write;

  // ===================================================================
  // Physical address by the level where the entry was found; region size
  // follows the level, the rest of the address comes from the virtual one
  function automatic logic [35:0] form_pa(input logic [1:0] lvl, input logic [31:0] e,
                                          input logic [31:0] va);
    case (lvl)
      `PTC_LEVEL_CONTEXT: form_pa = {e[31:28], va[31:0]};
      `PTC_LEVEL_1: form_pa = {e[31:20], va[23:0]};
      `PTC_LEVEL_2: form_pa = {e[31:14], va[17:0]};
      default: form_pa = {e[31:8], va[11:0]};
    endcase
  endfunction

  // ===================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      ptc_pkg::PTC_IDLE: begin
        s_d.bus_c = 1'b0;
        // Boot data mode with translation off flags local space
        s_d.boot_l = boot_select_bit && !translate_enable_bit;
        if (miss_valid) begin
          s_d.req = miss;
          s_d.mem_req = 1'b1;
          s_d.mem_we = 1'b0;
          s_d.st = ptc_pkg::PTC_FETCH;
          s_d.bus_c = sys_cacheable_bit;
          s_d.boot_l = 1'b0;
          if (hit_instr || hit_data) begin
            // Straight to level 3 through the cached pointer
            s_d.lvl = `PTC_LEVEL_3;
            s_d.addr = {hit_instr ? s_q.ip[31:4] : s_q.dp[31:4],
                        miss.va[`PTC_INDEX3_HI:`PTC_INDEX3_LO], 2'b00};
          end else if (s_q.root_v) begin
            s_d.lvl = `PTC_LEVEL_1;
            s_d.addr = {s_q.root[31:6], miss.va[`PTC_INDEX1_HI:`PTC_INDEX1_LO],
                        2'b00};
          end else begin
            s_d.lvl = `PTC_LEVEL_CONTEXT;
            s_d.addr = {context_table_base_reg, context_number_reg, 2'b00};
          end
        end
      end
      ptc_pkg::PTC_FETCH: begin
        if (mem_ack) begin
          s_d.mem_req = 1'b0;
          s_d.res.level = s_q.lvl;
          s_d.res.translation_entry = mem_rdata;
          s_d.res.pa = form_pa(s_q.lvl, mem_rdata, s_q.req.va);
          s_d.res.err_invalid = 1'b0;
          s_d.res.err_translation = 1'b0;
          if (mem_err) begin
            s_d.res.err_translation = 1'b1;
            s_d.done = 1'b1;
            s_d.st = ptc_pkg::PTC_IDLE;
          end else begin
            case (rd_type)
              `PTC_ENTRY_INVALID: begin
                s_d.res.err_invalid = 1'b1;
                s_d.done = 1'b1;
                s_d.st = ptc_pkg::PTC_IDLE;
              end
              `PTC_ENTRY_POINTER: begin
                if (s_q.lvl == `PTC_LEVEL_3) begin
                  // No table below level 3
                  s_d.res.err_translation = 1'b1;
                  s_d.done = 1'b1;
                  s_d.st = ptc_pkg::PTC_IDLE;
                end else begin
                  s_d.mem_req = 1'b1;
                  s_d.lvl = s_q.lvl + 2'h1;
                  if (s_q.lvl == `PTC_LEVEL_CONTEXT) begin
                    s_d.root = mem_rdata;
                    s_d.root_v = 1'b1;
                    s_d.addr = {mem_rdata[31:6],
                                s_q.req.va[`PTC_INDEX1_HI:`PTC_INDEX1_LO], 2'b00};
                  end else if (s_q.lvl == `PTC_LEVEL_1) begin
                    s_d.addr = {mem_rdata[31:4],
                                s_q.req.va[`PTC_INDEX2_HI:`PTC_INDEX2_LO], 2'b00};
                  end else begin
                    s_d.addr = {mem_rdata[31:4],
                                s_q.req.va[`PTC_INDEX3_HI:`PTC_INDEX3_LO], 2'b00};
                    // Only a mismatching walk gets here, and it goes to level 3
                    if (!s_q.req.no_fill) begin
                      if (s_q.req.is_instr) begin
                        s_d.ip = mem_rdata;
                        s_d.ip_v = 1'b1;
                        s_d.instr_index_tag = s_q.req.va[`PTC_INDEX1_HI:`PTC_INDEX2_LO];
                      end else begin
                        s_d.dp = mem_rdata;
                        s_d.dp_v = 1'b1;
                        s_d.data_index_tag = s_q.req.va[`PTC_INDEX1_HI:`PTC_INDEX2_LO];
                      end
                    end
                  end
                end
              end
              `PTC_ENTRY_TRANSLATION: begin
                s_d.bus_c = sys_cacheable_bit;
                // Write back only when a flag actually changes
                if (!mem_rdata[`PTC_REFERENCED_BIT] ||
                    (s_q.req.is_write && !mem_rdata[`PTC_MODIFIED_BIT])) begin
                  s_d.wdata = mem_rdata;
                  s_d.wdata[`PTC_REFERENCED_BIT] = 1'b1;
                  s_d.wdata[`PTC_MODIFIED_BIT] = mem_rdata[`PTC_MODIFIED_BIT] ||
                                                 s_q.req.is_write;
                  s_d.res.translation_entry = s_d.wdata;
                  s_d.mem_req = 1'b1;
                  s_d.mem_we = 1'b1;
                  s_d.st = ptc_pkg::PTC_UPDATE;
                end else begin
                  s_d.done = 1'b1;
                  s_d.st = ptc_pkg::PTC_IDLE;
                end
              end
              default: begin
                s_d.res.err_translation = 1'b1;
                s_d.done = 1'b1;
                s_d.st = ptc_pkg::PTC_IDLE;
              end
            endcase
          end
        end
      end
      ptc_pkg::PTC_UPDATE: begin
        if (mem_ack) begin
          s_d.mem_req = 1'b0;
          s_d.mem_we = 1'b0;
          s_d.res.err_translation = mem_err;
          s_d.done = 1'b1;
          s_d.st = ptc_pkg::PTC_IDLE;
        end
      end
      default: begin
        s_d.st = ptc_pkg::PTC_IDLE;
        s_d.mem_req = 1'b0;
      end
    endcase
    // Invalidation beats a fill in the same cycle: the fill may be stale
    if (tlb_flush || inv_all) begin
      s_d.ip_v = 1'b0;
      s_d.dp_v = 1'b0;
    end
    if (inv_all) begin
      s_d.root_v = 1'b0;
    end
    s_d.ready = (s_d.st == ptc_pkg::PTC_IDLE);
  end

  // ===================================================================
  // State register; reset clears every valid bit
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_q <= '0;
      s_q.st <= ptc_pkg::PTC_IDLE;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign miss_ready = s_q.ready;
  assign result_valid = s_q.done;
  assign result = s_q.res;
  assign mem_req = s_q.mem_req;
  assign mem_we = s_q.mem_we;
  assign mem_addr = s_q.addr;
  assign mem_wdata = s_q.wdata;
  assign bus_cacheable_indicator = s_q.bus_c;
  assign boot_local_indicator = s_q.boot_l;
  assign pointer_cache_valid = {s_q.dp_v, s_q.ip_v, s_q.root_v};

  // ===================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence read_ack_s;
    s_q.st == ptc_pkg::PTC_FETCH && mem_ack && !mem_err;
  endsequence

  sequence hit_start_s;
    s_q.st == ptc_pkg::PTC_IDLE && miss_valid && (hit_instr || hit_data);
  endsequence

  root_index_a: assert property (mem_req && !mem_we && s_q.lvl == `PTC_LEVEL_1
    |-> mem_addr[9:2] == s_q.req.va[31:24]) else $error("level 1 index misplaced");
  ptr_index_a: assert property (mem_req && !mem_we && s_q.lvl == `PTC_LEVEL_2
    |-> mem_addr[7:2] == s_q.req.va[23:18]) else $error("level 2 index misplaced");
  word_align_a: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
    else $error("table address not word aligned");
  invalid_err_a: assert property (read_ack_s and rd_type == `PTC_ENTRY_INVALID
    |=> result_valid && result.err_invalid) else $error("invalid entry not flagged");
  reserved_err_a: assert property (read_ack_s and rd_type == `PTC_ENTRY_RESERVED
    |=> result_valid && result.err_translation) else $error("reserved entry not flagged");
  ref_write_a: assert property (mem_req && mem_we |-> mem_wdata[`PTC_REFERENCED_BIT])
    else $error("referenced flag not set on write back");
  mod_write_a: assert property (mem_req && mem_we && s_q.req.is_write
    |-> mem_wdata[`PTC_MODIFIED_BIT]) else $error("modified flag not set");
  level3_pa_a: assert property (result_valid && result.level == `PTC_LEVEL_3
    |-> result.pa[11:0] == s_q.req.va[11:0]
        && result.pa[35:12] == result.translation_entry[31:8])
    else $error("level 3 physical address wrong");
  context_pa_a: assert property (result_valid && result.level == `PTC_LEVEL_CONTEXT
    |-> result.pa[35:32] == result.translation_entry[31:28])
    else $error("context level physical address wrong");
  cached_hit_a: assert property (hit_start_s
    |=> mem_req && s_q.lvl == `PTC_LEVEL_3) else $error("cached pointer not used");
  flush_clear_a: assert property (tlb_flush |=> !s_q.ip_v && !s_q.dp_v)
    else $error("flush left a level 2 pointer valid");
  context_clear_a: assert property (inv_all |=> pointer_cache_valid == 3'b000)
    else $error("context change left pointer cache valid");

  // Walk start, and a cold start that must go through the context table
  sequence take_s;
    s_q.st == ptc_pkg::PTC_IDLE && miss_valid;
  endsequence

  sequence ctx_start_s;
    s_q.st == ptc_pkg::PTC_IDLE && miss_valid && !hit_instr && !hit_data && !s_q.root_v;
  endsequence

  walk_ind_a: assert property (take_s
    |=> bus_cacheable_indicator == $past(sys_cacheable_bit) && !boot_local_indicator)
    else $error("bus indicators wrong during walk");
  ctx_addr_a: assert property (ctx_start_s
    |=> mem_addr[35:14] == $past(context_table_base_reg)
        && mem_addr[13:2] == $past(context_number_reg))
    else $error("context entry address wrong");
  no_fill_a: assert property (read_ack_s and s_q.lvl == `PTC_LEVEL_2
      && s_q.req.no_fill && !tlb_flush && !inv_all
    |=> $stable(pointer_cache_valid) && $stable(s_q.ip) && $stable(s_q.dp))
    else $error("no-fill walk changed a level 2 pointer");
  tag_fill_a: assert property (read_ack_s and s_q.lvl == `PTC_LEVEL_2
      && rd_type == `PTC_ENTRY_POINTER && !s_q.req.no_fill && !tlb_flush && !inv_all
    |=> (s_q.req.is_instr ? s_q.ip_v && s_q.instr_index_tag == s_q.req.va[31:18]
                          : s_q.dp_v && s_q.data_index_tag == s_q.req.va[31:18]))
    else $error("level 2 pointer or tag not captured");

endmodule

// file: bench/ptc_mem_model.sv
// Behavioural page-table memory seen by the walker's word port.
// Assumes one outstanding request, held until the ack edge.
`timescale 1ns/10ps

module ptc_mem_model (
  // Clock
  input wire logic mclk,
  // Request from the walker
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [35:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] lat,
  // Answer to the walker
  output logic mem_ack,
  output logic mem_err,
  output logic [31:0] mem_rdata
);
  // =====================================================================
  // Storage and access log
  logic [31:0] words [logic [35:0]];
  logic [35:0] log_q [$];
  logic [3:0] wait_q;

  initial begin
    mem_ack = 1'b0;
    mem_err = 1'b0;
    mem_rdata = 32'h0000_0000;
    wait_q = 4'h0;
  end

  // Answer after lat idle cycles; read data flips after each ack and while no request is up, and holds during the wait
  always @(posedge mclk) begin
    if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && wait_q == lat) begin
      wait_q <= 4'h0;
      mem_ack <= 1'b1;
      log_q.push_back(mem_addr);
      if (mem_we) begin
        words[mem_addr] = mem_wdata;
      end else begin
        mem_rdata <= words.exists(mem_addr) ? words[mem_addr] : 32'h0000_0000;
      end
    end else if (mem_req) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      mem_rdata <= ~mem_rdata; // Released bus must not look stable
    end
  end
endmodule

// file: bench/page_table_entry_and_pointer_cache_tb_top.sv
// Self-checking bench for the walker and its pointer cache.
// Assumes the memory model answers from a word table set by the scenarios.
`timescale 1ns/10ps

module page_table_entry_and_pointer_cache_tb_top;
  // =====================================================================
  // Signals and fixed table contents
  localparam logic [21:0] BASE = 22'h000010;
  localparam logic [31:0] ROOT = 32'h0000_1001;
  localparam logic [31:0] P1 = 32'h0000_2001;
  localparam logic [31:0] P2 = 32'h0000_3001;
  localparam logic [31:0] VA1 = 32'h1234_5678;
  localparam logic [31:0] VA2 = 32'h1234_9abc;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic miss_valid = 1'b0;
  ptc_pkg::ptc_miss_t miss = '0;
  ptc_pkg::ptc_result_t result;
  logic miss_ready, result_valid, mem_req, mem_we, mem_ack, mem_err;
  logic [11:0] ctx = 12'h005;
  logic ctx_wr = 1'b0, base_wr = 1'b0, flush = 1'b0;
  logic [35:0] mem_addr;
  logic [31:0] mem_wdata, mem_rdata;
  logic bus_c, boot_l, sys_c = 1'b1;
  logic [2:0] pc_valid;
  logic [3:0] lat = 4'h0;
  logic [35:0] exp_q [$];
  int err_total = 0, n_tests = 0, cyc = 0;

  always #12.5 mclk = ~mclk;

  ptc_walker i_dut (.mclk(mclk), .srst(srst), .miss_valid(miss_valid), .miss(miss),
    .result(result), .miss_ready(miss_ready), .result_valid(result_valid),
    .context_number_reg(ctx), .context_number_write(ctx_wr),
    .context_table_base_reg(BASE), .context_table_base_write(base_wr),
    .tlb_flush(flush), .sys_cacheable_bit(sys_c), .boot_select_bit(1'b1),
    .translate_enable_bit(1'b0), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_err(mem_err),
    .mem_rdata(mem_rdata), .bus_cacheable_indicator(bus_c),
    .boot_local_indicator(boot_l), .pointer_cache_valid(pc_valid));

  ptc_mem_model i_mem (.mclk(mclk), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .lat(lat), .mem_ack(mem_ack),
    .mem_err(mem_err), .mem_rdata(mem_rdata));

  // =====================================================================
  // Expected table addresses
  function automatic logic [35:0] ctx_a(input logic [11:0] c);
    return {BASE, c, 2'b00};
  endfunction
  function automatic logic [35:0] l1a(input logic [31:0] p, input logic [31:0] va);
    return {p[31:6], va[31:24], 2'b00};
  endfunction
  function automatic logic [35:0] l2a(input logic [31:0] p, input logic [31:0] va);
    return {p[31:4], va[23:18], 2'b00};
  endfunction
  function automatic logic [35:0] l3a(input logic [31:0] p, input logic [31:0] va);
    return {p[31:4], va[17:12], 2'b00};
  endfunction

  // =====================================================================
  // Compares, report and hang guard
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_addr(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: address %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("errors %0d comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Whole run needs well under two hundred cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end

  // =====================================================================
  // Shared drivers
  task automatic ex(input logic [35:0] a);
    exp_q.push_back(a);
  endtask
  task automatic set_path(input logic [31:0] va);
    i_mem.words[ctx_a(12'h005)] = ROOT;
    i_mem.words[l1a(ROOT, va)] = P1;
    i_mem.words[l2a(P1, va)] = P2;
  endtask
  task automatic pulse(input int k);
    @(negedge mclk);
    ctx_wr = (k == 0);
    base_wr = (k == 1);
    flush = (k == 2);
    @(negedge mclk);
    {ctx_wr, base_wr, flush} = 3'h0;
    @(negedge mclk);
  endtask
  task automatic chk_pc(input logic [2:0] e);
    chk_word({29'h0, pc_valid}, {29'h0, e});
  endtask
  // One miss; judges result fields and the address trace
  task automatic walk(input logic [31:0] va, input logic instr, input logic wr,
      input logic nf, input logic [35:0] epa, input logic [31:0] ept,
      input logic [1:0] elv, input logic [1:0] eerr);
    int n;
    i_mem.log_q.delete();
    @(negedge mclk);
    miss_valid = 1'b1;
    miss = {va, instr, wr, nf};
    @(negedge mclk);
    miss_valid = 1'b0;
    chk_word({31'h0, bus_c}, {31'h0, sys_c});
    chk_word({31'h0, boot_l}, 32'h0);
    n = 0;
    while (result_valid !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    chk_word({31'h0, result_valid}, 32'h1);
    chk_word({30'h0, result.err_invalid, result.err_translation}, {30'h0, eerr});
    if (eerr == 2'h0) begin
      chk_word({30'h0, result.level}, {30'h0, elv});
      chk_addr(result.pa, epa);
      chk_word(result.translation_entry, ept);
    end
    chk_word(i_mem.log_q.size(), exp_q.size());
    for (int i = 0; i < exp_q.size(); i++) begin
      chk_addr(i_mem.log_q[i], exp_q[i]);
    end
    exp_q.delete();
  endtask

  // =====================================================================
  // Scenarios
  task automatic t_cold_fill();
    set_path(VA1);
    i_mem.words[l3a(P2, VA1)] = 32'habcdef82;
    ex(ctx_a(12'h005));
    ex(l1a(ROOT, VA1));
    ex(l2a(P1, VA1));
    ex(l3a(P2, VA1));
    ex(l3a(P2, VA1));
    walk(VA1, 0, 0, 0, {24'habcdef, VA1[11:0]}, 32'habcdefa2, 2'h3, 2'h0);
    chk_word(i_mem.words[l3a(P2, VA1)], 32'habcdefa2);
    chk_pc(3'h5);
  endtask
  task automatic t_cached_l2();
    lat = 4'h3;
    i_mem.words[l3a(P2, VA2)] = 32'h0bbbbba2;
    ex(l3a(P2, VA2));
    ex(l3a(P2, VA2));
    walk(VA2, 0, 1, 0, {24'h0bbbbb, VA2[11:0]}, 32'h0bbbbbe2, 2'h3, 2'h0);
    chk_word(i_mem.words[l3a(P2, VA2)], 32'h0bbbbbe2);
  endtask
  task automatic t_instr_root();
    lat = 4'h1;
    ex(l1a(ROOT, VA1));
    ex(l2a(P1, VA1));
    ex(l3a(P2, VA1));
    walk(VA1, 1, 0, 0, {24'habcdef, VA1[11:0]}, 32'habcdefa2, 2'h3, 2'h0);
    chk_pc(3'h7);
  endtask
  task automatic t_short_walks();
    i_mem.words[l1a(ROOT, 32'h5600_0123)] = 32'h777abca2;
    ex(l1a(ROOT, 32'h5600_0123));
    walk(32'h5600_0123, 0, 0, 0, 36'h777000123, 32'h777abca2, 2'h1, 2'h0);
    i_mem.words[l1a(ROOT, 32'h7800_4321)] = 32'h0000_4001;
    i_mem.words[l2a(32'h4001, 32'h7800_4321)] = 32'h888abca2;
    ex(l1a(ROOT, 32'h7800_4321));
    ex(l2a(32'h4001, 32'h7800_4321));
    walk(32'h7800_4321, 0, 0, 0, {18'h2222a, 18'h04321}, 32'h888abca2, 2'h2, 2'h0);
    chk_pc(3'h7);
  endtask
  task automatic t_errors();
    // Uncached control bit here, so the walk indicator must follow it low
    sys_c = 1'b0;
    i_mem.words[l1a(ROOT, 32'h9a00_0000)] = 32'h0000_0000;
    i_mem.words[l1a(ROOT, 32'h9b00_0000)] = 32'h0000_0003;
    ex(l1a(ROOT, 32'h9a00_0000));
    walk(32'h9a00_0000, 0, 0, 0, 36'h0, 32'h0, 2'h1, 2'h2);
    ex(l1a(ROOT, 32'h9b00_0000));
    walk(32'h9b00_0000, 0, 0, 0, 36'h0, 32'h0, 2'h1, 2'h1);
    sys_c = 1'b1;
  endtask
  task automatic t_flush_nofill();
    pulse(2);
    chk_pc(3'h1);
    i_mem.words[l3a(P2, 32'h1234_7000)] = 32'h0000_5001;
    ex(l1a(ROOT, 32'h1234_7000));
    ex(l2a(P1, 32'h1234_7000));
    ex(l3a(P2, 32'h1234_7000));
    walk(32'h1234_7000, 0, 0, 1, 36'h0, 32'h0, 2'h3, 2'h1);
    chk_pc(3'h1);
  endtask
  task automatic t_context();
    pulse(1);
    chk_pc(3'h0);
    ex(ctx_a(12'h005));
    ex(l1a(ROOT, VA1));
    ex(l2a(P1, VA1));
    ex(l3a(P2, VA1));
    walk(VA1, 0, 0, 0, {24'habcdef, VA1[11:0]}, 32'habcdefa2, 2'h3, 2'h0);
    chk_pc(3'h5);
    ctx = 12'h006;
    pulse(0);
    chk_pc(3'h0);
    i_mem.words[ctx_a(12'h006)] = 32'hc12345a2;
    ex(ctx_a(12'h006));
    walk(32'h0abc_def0, 0, 0, 0, 36'hc0abcdef0, 32'hc12345a2, 2'h0, 2'h0);
    chk_pc(3'h0);
  endtask

  // =====================================================================
  // Main sequence
  initial begin
    repeat (10) @(negedge mclk);
    srst = 1'b0;
    @(negedge mclk);
    @(negedge mclk);
    chk_pc(3'h0);
    chk_word({31'h0, boot_l}, 32'h1);
    chk_word({31'h0, miss_ready}, 32'h1);
    t_cold_fill();
    t_cached_l2();
    t_instr_root();
    t_short_walks();
    t_errors();
    t_flush_nofill();
    t_context();
    test_done();
  end
endmodule
